// ===== rtl/upt_pkg.sv
// constants and types shared by the user array integrity checker
package upt_pkg;
    // ***********************************
    // mirror array layout
    // ***********************************
    localparam int UPT_NUM_BYTES = 12;
    localparam logic [3:0] UPT_IDX_LAST = 4'hB;
    localparam logic [3:0] UPT_IDX_TYPE = 4'h0;
    localparam logic [3:0] UPT_IDX_CFG0 = 4'h1;
    localparam logic [3:0] UPT_IDX_CFG1 = 4'h2;
    localparam logic [3:0] UPT_IDX_CFG2 = 4'h3;
    localparam int UPT_LOCK_BIT = 7;
    localparam int UPT_PULSE_EN_BIT = 5;
    localparam int UPT_PROT_W = 70;
    localparam int UPT_CODE_W = 8;
    localparam logic [7:0] UPT_CODE_POLY = 8'h07;
    localparam logic [7:0] UPT_CODE_SEED = 8'hFF;
    localparam logic [7:0] UPT_BYTE_RESET = 8'h00;

    // writable bits per mirror byte; last user byte has only its upper nibble
    function automatic logic [7:0] upt_mask(input logic [3:0] idx);
        logic [7:0] m;
        m = 8'hFF;
        case (idx)
            4'h0: m = 8'hC0;
            4'h1: m = 8'h80;
            4'h2: m = 8'h03;
            4'h3: m = 8'hAF;
            4'hB: m = 8'hF0;
            default: m = 8'hFF;
        endcase
        return m;
    endfunction

    // ***********************************
    // register map (byte addresses)
    // ***********************************
    localparam int UPT_ADDR_W = 8;
    localparam logic [7:0] UPT_REG_CTRL = 8'h00;
    localparam logic [7:0] UPT_REG_NVM_WR = 8'h04;
    localparam logic [7:0] UPT_REG_STATUS = 8'h08;
    localparam logic [7:0] UPT_REG_IRQ_STAT = 8'h0C;
    localparam logic [7:0] UPT_REG_IRQ_MASK = 8'h10;
    localparam logic [7:0] UPT_REG_MIRROR = 8'h40;
    localparam logic [7:0] UPT_REG_MIRROR_END = 8'h6C;
    localparam int UPT_CTRL_CLEAR_BIT = 0;
    localparam int UPT_NVM_IDX_LSB = 8;
    localparam int UPT_ST_LOCK_ACT = 0;
    localparam int UPT_ST_ERROR = 1;
    localparam int UPT_ST_BUSY = 2;
    localparam int UPT_ST_FUSE_LOCK = 3;
    localparam int UPT_ST_CALC_LSB = 8;
    localparam int UPT_ST_STORED_LSB = 16;
    localparam int UPT_IRQ_W = 3;
    localparam int UPT_IRQ_ERROR = 0;
    localparam int UPT_IRQ_DONE = 1;
    localparam int UPT_IRQ_INHIBIT = 2;
    localparam logic [1:0] UPT_HRESP_OKAY = 2'h0;

    typedef enum {UPT_RO_IDLE, UPT_RO_COPY, UPT_RO_EVAL} upt_ro_state_t;
endpackage

// ===== rtl/upt_code_if.sv
// carries the protected mirror bits to the code generator and the code back
`timescale 1ns/1ps
`default_nettype none
interface upt_code_if;
    logic [upt_pkg::UPT_PROT_W-1:0] data;
    logic [upt_pkg::UPT_CODE_W-1:0] code;
    modport gen (input data, output code);
    modport user (output data, input code);
endinterface
`default_nettype wire

// ===== rtl/upt_code_gen.sv
// combinational error detection code over the protected user bits
`timescale 1ns/1ps
`default_nettype none
module upt_code_gen
(
    upt_code_if.gen cif // protected bits in, code out
);
    import upt_pkg::*;

    // bits enter lsb first, lowest mirror byte first
    always_comb
    begin
        logic [UPT_CODE_W-1:0] c;
        logic fb;
        c = UPT_CODE_SEED;
        fb = 1'b0;
        for (int i = 0; i < UPT_PROT_W; i++)
        begin
            fb = c[UPT_CODE_W-1] ^ cif.data[i];
            c = {c[UPT_CODE_W-2:0], 1'b0};
            if (fb)
            begin
                c = c ^ UPT_CODE_POLY;
            end
        end
        cif.code = c;
    end
endmodule // upt_code_gen
`default_nettype wire

// ===== rtl/upt_user_otp_check.sv
// user otp mirror, readout, nvm write and continuous integrity check
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module upt_user_otp_check
(
    input wire logic clk_sys_i, // system clock, 200 MHz
    input wire logic srst_i, // synchronous reset, active high
    input wire logic hsel_i, // ahb slave select
    input wire logic [31:0] haddr_i, // ahb address
    input wire logic [1:0] htrans_i, // ahb transfer type
    input wire logic hwrite_i, // ahb write
    input wire logic [2:0] hsize_i, // ahb size, word only
    input wire logic hready_i, // ahb bus ready
    input wire logic [31:0] hwdata_i, // ahb write data
    output logic [31:0] hrdata_o, // ahb read data
    output logic hreadyout_o, // ahb slave ready
    output logic [1:0] hresp_o, // ahb response
    output logic irq_o, // level interrupt
    output logic data_error_o, // internal data error
    output logic lock_active_o, // user lock active
    output logic readout_busy_o // readout in progress
);
    import upt_pkg::*;

    // ***********************************
    // declarations
    // ***********************************
    logic [7:0] fuse_q [UPT_NUM_BYTES];
    logic [7:0] mirror_q [UPT_NUM_BYTES];
    logic [UPT_CODE_W-1:0] stored_code_q;
    logic store_pend_q;
    upt_ro_state_t ro_state_q;
    logic [3:0] ro_idx_q;
    logic busy_q;
    logic lock_active_q;
    logic data_error_q;
    logic wr_pend_q;
    logic [UPT_ADDR_W-1:0] wr_addr_q;
    logic [31:0] rd_d;
    logic [31:0] hrdata_q;
    logic [UPT_IRQ_W-1:0] irq_stat_q;
    logic [UPT_IRQ_W-1:0] irq_mask_q;
    logic [UPT_IRQ_W-1:0] irq_ev;
    logic irq_q;
    logic addr_ok;
    logic clear_cmd;
    logic nvm_wr;
    logic [3:0] nvm_idx;
    logic [7:0] nvm_data;
    logic nvm_inhibit;
    logic mismatch;
    logic [3:0] mir_idx;
    logic [UPT_CODE_W-1:0] calc_code;
    logic unused_ok;

    upt_code_if cif ();

    // ***********************************
    // code generation over the mirror
    // ***********************************
    // only mirror copies feed the generator; fuses are never read here
    assign cif.data = {mirror_q[11][7:4], mirror_q[10], mirror_q[9], mirror_q[8],
                       mirror_q[7], mirror_q[6], mirror_q[5], mirror_q[4],
                       mirror_q[UPT_IDX_CFG2][UPT_PULSE_EN_BIT], mirror_q[UPT_IDX_CFG2][3:0],
                       mirror_q[UPT_IDX_CFG1][1:0], mirror_q[UPT_IDX_CFG0][7],
                       mirror_q[UPT_IDX_TYPE][7:6]};
    assign calc_code = cif.code;

    // separate generator from any factory array
    upt_code_gen u_code_gen
    (
        .cif (cif.gen)
    );

    // ***********************************
    // ahb-lite slave, zero wait states
    // ***********************************
    assign addr_ok = hsel_i && htrans_i[1] && hready_i;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end
        else
        begin
            wr_pend_q <= addr_ok && hwrite_i;
            wr_addr_q <= haddr_i[UPT_ADDR_W-1:0];
        end
    end

    assign mir_idx = haddr_i[5:2];

    always_comb
    begin
        rd_d = '0;
        if (haddr_i[UPT_ADDR_W-1:0] == UPT_REG_STATUS)
        begin
            rd_d[UPT_ST_LOCK_ACT] = lock_active_q;
            rd_d[UPT_ST_ERROR] = data_error_q;
            rd_d[UPT_ST_BUSY] = (ro_state_q != UPT_RO_IDLE);
            rd_d[UPT_ST_FUSE_LOCK] = fuse_q[UPT_IDX_CFG2][UPT_LOCK_BIT];
            rd_d[UPT_ST_CALC_LSB +: UPT_CODE_W] = calc_code;
            rd_d[UPT_ST_STORED_LSB +: UPT_CODE_W] = stored_code_q;
        end
        else if (haddr_i[UPT_ADDR_W-1:0] == UPT_REG_IRQ_STAT)
        begin
            rd_d[UPT_IRQ_W-1:0] = irq_stat_q;
        end
        else if (haddr_i[UPT_ADDR_W-1:0] == UPT_REG_IRQ_MASK)
        begin
            rd_d[UPT_IRQ_W-1:0] = irq_mask_q;
        end
        else if (haddr_i[UPT_ADDR_W-1:0] >= UPT_REG_MIRROR
                 && haddr_i[UPT_ADDR_W-1:0] <= UPT_REG_MIRROR_END)
        begin
            rd_d[7:0] = mirror_q[mir_idx];
        end
    end

    // read data is captured at the address phase edge and stands in the data phase
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            hrdata_q <= '0;
        end
        else if (addr_ok && !hwrite_i)
        begin
            hrdata_q <= rd_d;
        end
    end

    assign hrdata_o = hrdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = UPT_HRESP_OKAY;

    // ***********************************
    // decoded write commands
    // ***********************************
    assign clear_cmd = wr_pend_q && (wr_addr_q == UPT_REG_CTRL)
                       && hwdata_i[UPT_CTRL_CLEAR_BIT];
    assign nvm_idx = hwdata_i[UPT_NVM_IDX_LSB +: 4];
    assign nvm_data = hwdata_i[7:0] & upt_mask(hwdata_i[UPT_NVM_IDX_LSB +: 4]);
    // writes during readout are dropped: the copy would overwrite them anyway
    assign nvm_wr = wr_pend_q && (wr_addr_q == UPT_REG_NVM_WR)
                    && (nvm_idx <= UPT_IDX_LAST) && (ro_state_q == UPT_RO_IDLE);
    assign nvm_inhibit = nvm_wr && lock_active_q;

    // ***********************************
    // fuse array and stored code
    // ***********************************
    // fuses are modelled as flops; otp programming can only set bits
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            for (int i = 0; i < UPT_NUM_BYTES; i++)
            begin
                fuse_q[i] <= UPT_BYTE_RESET;
            end
        end
        else if (nvm_wr && !lock_active_q)
        begin
            fuse_q[nvm_idx] <= fuse_q[nvm_idx] | nvm_data;
        end
    end

    // the code is taken one cycle after the lock write, once the mirror holds it
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            store_pend_q <= 1'b0;
            stored_code_q <= UPT_CODE_SEED;
        end
        else
        begin
            store_pend_q <= nvm_wr && !lock_active_q && (nvm_idx == UPT_IDX_CFG2)
                            && nvm_data[UPT_LOCK_BIT];
            if (store_pend_q)
            begin
                stored_code_q <= calc_code;
            end
        end
    end

    // ***********************************
    // mirror registers
    // ***********************************
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            for (int i = 0; i < UPT_NUM_BYTES; i++)
            begin
                mirror_q[i] <= UPT_BYTE_RESET;
            end
        end
        else if (ro_state_q == UPT_RO_COPY)
        begin
            mirror_q[ro_idx_q] <= fuse_q[ro_idx_q];
        end
        else if (nvm_wr)
        begin
            // updated even when locked, so a locked array shows a mismatch
            mirror_q[nvm_idx] <= nvm_data;
        end
    end

    // ***********************************
    // automatic readout sequencer
    // ***********************************
    // readout starts out of reset and on the clear command only
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            ro_state_q <= UPT_RO_COPY;
            ro_idx_q <= '0;
            busy_q <= 1'b1;
        end
        else
        begin
            unique case (ro_state_q)
                UPT_RO_IDLE:
                begin
                    if (clear_cmd)
                    begin
                        ro_state_q <= UPT_RO_COPY;
                        ro_idx_q <= '0;
                        busy_q <= 1'b1;
                    end
                end
                UPT_RO_COPY:
                begin
                    if (ro_idx_q == UPT_IDX_LAST)
                    begin
                        ro_state_q <= UPT_RO_EVAL;
                    end
                    ro_idx_q <= ro_idx_q + 4'h1;
                end
                UPT_RO_EVAL:
                begin
                    ro_state_q <= UPT_RO_IDLE;
                    ro_idx_q <= '0;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // lock is active only if both fuse and freshly read mirror bit are set
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            lock_active_q <= 1'b0;
        end
        else if (clear_cmd && ro_state_q == UPT_RO_IDLE)
        begin
            lock_active_q <= 1'b0;
        end
        else if (ro_state_q == UPT_RO_EVAL)
        begin
            lock_active_q <= fuse_q[UPT_IDX_CFG2][UPT_LOCK_BIT]
                             && mirror_q[UPT_IDX_CFG2][UPT_LOCK_BIT];
        end
    end

    // ***********************************
    // continuous compare and data error
    // ***********************************
    // compared every idle cycle while the lock is active, not once after readout
    assign mismatch = lock_active_q && (ro_state_q == UPT_RO_IDLE)
                      && (calc_code != stored_code_q);

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            data_error_q <= 1'b0;
        end
        else if (mismatch)
        begin
            data_error_q <= 1'b1;
        end
        else if (ro_state_q == UPT_RO_EVAL)
        begin
            data_error_q <= 1'b0;
        end
    end

    // ***********************************
    // interrupts
    // ***********************************
    always_comb
    begin
        irq_ev = '0;
        irq_ev[UPT_IRQ_ERROR] = mismatch && !data_error_q;
        irq_ev[UPT_IRQ_DONE] = (ro_state_q == UPT_RO_EVAL);
        irq_ev[UPT_IRQ_INHIBIT] = nvm_inhibit;
    end

    // a new event in the clearing cycle wins over the write-one-to-clear
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end
        else
        begin
            if (wr_pend_q && wr_addr_q == UPT_REG_IRQ_STAT)
            begin
                irq_stat_q <= (irq_stat_q & ~hwdata_i[UPT_IRQ_W-1:0]) | irq_ev;
            end
            else
            begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
            if (wr_pend_q && wr_addr_q == UPT_REG_IRQ_MASK)
            begin
                irq_mask_q <= hwdata_i[UPT_IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ***********************************
    // outputs
    // ***********************************
    assign irq_o = irq_q;
    assign data_error_o = data_error_q;
    assign lock_active_o = lock_active_q;
    assign readout_busy_o = busy_q;

    // only whole-word accesses are supported, the upper address bits alias
    assign unused_ok = ^{haddr_i[31:UPT_ADDR_W], hsize_i, htrans_i[0], hwdata_i[31:12]};
endmodule // upt_user_otp_check
`default_nettype wire

// ===== sim/upt_user_otp_check_assertions.sv
// port checker for the user otp integrity block
`timescale 1ns/1ps
`default_nettype none
module upt_user_otp_check_assertions
(
    input wire logic clk_sys_i, // clock
    input wire logic srst_i, // reset
    input wire logic [1:0] hresp_o, // response
    input wire logic hreadyout_o, // ready out
    input wire logic data_error_o, // data error
    input wire logic lock_active_o, // lock active
    input wire logic readout_busy_o // readout busy
);
    // ****
    // properties
    // ****
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    property p_err_lock;
        $rose(data_error_o) |-> $past(lock_active_o);
    endproperty
    a_err_lock: assert property (p_err_lock)
        else $error("error raised while unlocked");
    property p_err_idle;
        $rose(data_error_o) |-> !$past(readout_busy_o);
    endproperty
    a_err_idle: assert property (p_err_idle)
        else $error("error raised during readout");
    property p_err_hold;
        data_error_o && !readout_busy_o |=> data_error_o;
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("error dropped outside readout");
    property p_err_fall;
        $fell(data_error_o) |-> $past(readout_busy_o);
    endproperty
    a_err_fall: assert property (p_err_fall)
        else $error("error cleared without readout");
    property p_lock_busy;
        readout_busy_o |-> !lock_active_o;
    endproperty
    a_lock_busy: assert property (p_lock_busy)
        else $error("lock active during readout");
    property p_lock_chg;
        $changed(lock_active_o) |-> readout_busy_o || $past(readout_busy_o);
    endproperty
    a_lock_chg: assert property (p_lock_chg)
        else $error("lock changed outside readout");
    property p_busy_len;
        $rose(readout_busy_o) |-> ##12 readout_busy_o ##1 !readout_busy_o;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("readout length wrong");
    property p_bus;
        hreadyout_o && hresp_o == 2'h0;
    endproperty
    a_bus: assert property (p_bus)
        else $error("slave not ready or not okay");
endmodule // upt_user_otp_check_assertions
bind upt_user_otp_check upt_user_otp_check_assertions i_chk (.clk_sys_i, .srst_i, .hresp_o,
    .hreadyout_o, .data_error_o, .lock_active_o, .readout_busy_o);
`default_nettype wire

// ===== sim/upt_ahb_master.sv
// bus master model issuing nvm writes, clear commands and reads
`timescale 1ns/1ps
`default_nettype none
module upt_ahb_master
(
    input wire logic clk_i, // clock
    input wire logic hready_i, // bus ready
    input wire logic [31:0] hrdata_i, // read data
    output logic hsel_o, // select
    output logic [31:0] haddr_o, // address
    output logic [1:0] htrans_o, // transfer
    output logic hwrite_o, // write
    output logic [2:0] hsize_o, // size
    output logic [31:0] hwdata_o // write data
);
    initial
    begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end
    // ****
    // single word transfer, called just after a rising edge
    // ****
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel_o <= 1'b1;
        haddr_o <= {24'h0, a};
        htrans_o <= 2'h2;
        hwrite_o <= w;
        // released data never keeps its old value
        hwdata_o <= ~hwdata_o;
        @(posedge clk_i);
        while (hready_i !== 1'b1) @(posedge clk_i);
        hsel_o <= 1'b0;
        htrans_o <= 2'h0;
        hwdata_o <= wd;
        @(posedge clk_i);
        while (hready_i !== 1'b1) @(posedge clk_i);
        rd = hrdata_i;
    endtask
endmodule // upt_ahb_master
`default_nettype wire

// ===== sim/user_otp_error_detect_tb.sv
// self-checking bench for the user otp integrity checker
`timescale 1ns/1ps
`default_nettype none
module user_otp_error_detect_tb;
    import upt_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel, hwrite, hrdy, irq, err, lock, busy;
    logic [1:0] htrans, hresp;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] exp_m [12];
    logic [7:0] sc;
    int num_errors = 0;
    int comparisons = 0;
    initial forever #2.5 clk = ~clk;
    upt_user_otp_check i_dut (.clk_sys_i(clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hrdy),
        .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .irq_o(irq), .data_error_o(err), .lock_active_o(lock), .readout_busy_o(busy));
    upt_ahb_master i_bus (.clk_i(clk), .hready_i(hrdy), .hrdata_i(hrdata), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
        .hwdata_o(hwdata));
    // ****
    // helpers
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic end_sim;
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_bus.xfer(a, 1'b1, d, rd);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] want);
        i_bus.xfer(a, 1'b0, 32'h0, rd);
        check(rd, want);
    endtask
    task automatic pins(input int n, input logic [2:0] want);
        repeat (n) @(posedge clk);
        check({29'h0, irq, err, lock}, {29'h0, want});
    endtask
    // writable bits of each mirror byte
    function automatic logic [7:0] msk(input int i);
        return i == 0 ? 8'hC0 : i == 1 ? 8'h80 : i == 2 ? 8'h03 : i == 3 ? 8'hAF :
            i == 11 ? 8'hF0 : 8'hFF;
    endfunction
    task automatic nvm(input int i, input logic [7:0] d);
        wr(UPT_REG_NVM_WR, {20'h0, i[3:0], d});
        exp_m[i] = d & msk(i);
    endtask
    // crc-8, poly 07, seed FF, protected bits fed lsb first
    function automatic logic [7:0] crc();
        logic [69:0] v;
        logic [7:0] c;
        v = {exp_m[11][7:4], exp_m[10], exp_m[9], exp_m[8], exp_m[7], exp_m[6], exp_m[5],
            exp_m[4], exp_m[3][5], exp_m[3][3:0], exp_m[2][1:0], exp_m[1][7], exp_m[0][7:6]};
        c = 8'hFF;
        for (int k = 0; k < 70; k++)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[k]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    function automatic logic [31:0] st(input logic [7:0] s, input logic lk, input logic e,
        input logic fl);
        return {8'h0, s, crc(), 4'h0, fl, 1'b0, e, lk};
    endfunction
    task automatic do_reset;
        srst <= 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        foreach (exp_m[i]) exp_m[i] = 8'h00;
        @(posedge clk);
        check({31'h0, busy}, 32'h1);
    endtask
    // readout length is fixed, so a fixed wait is enough
    task automatic idle;
        repeat (15) @(posedge clk);
        check({31'h0, busy}, 32'h0);
    endtask
    task automatic fill;
        for (int i = 0; i < 12; i++) nvm(i, i == 3 ? 8'h2F : 8'hFF);
    endtask
    task automatic mir;
        for (int i = 0; i < 12; i++) rdc(UPT_REG_MIRROR + 8'(4 * i), {24'h0, exp_m[i]});
    endtask
    // ****
    // tests
    // ****
    initial
    begin
        do_reset();
        idle();
        rdc(UPT_REG_STATUS, st(8'hFF, 1'b0, 1'b0, 1'b0));
        fill();
        mir();
        nvm(3, 8'hAF);
        repeat (3) @(posedge clk);
        sc = crc();
        rdc(UPT_REG_STATUS, st(sc, 1'b0, 1'b0, 1'b1));
        nvm(5, 8'h00);
        rdc(UPT_REG_STATUS, st(sc, 1'b0, 1'b0, 1'b1));
        pins(3, 3'h0);
        $display("test unlocked done");
        do_reset();
        idle();
        fill();
        nvm(3, 8'hAF);
        repeat (3) @(posedge clk);
        sc = crc();
        wr(UPT_REG_CTRL, 32'h1);
        idle();
        rdc(UPT_REG_STATUS, st(sc, 1'b1, 1'b0, 1'b1));
        mir();
        rdc(UPT_REG_IRQ_STAT, 32'h2);
        pins(2, 3'h1);
        wr(UPT_REG_IRQ_MASK, 32'h2);
        pins(2, 3'h5);
        wr(UPT_REG_IRQ_STAT, 32'h2);
        pins(2, 3'h1);
        $display("test lock done");
        wr(UPT_REG_IRQ_MASK, 32'h1);
        nvm(4, 8'h00);
        pins(3, 3'h7);
        rdc(UPT_REG_MIRROR + 8'h10, 32'h0);
        rdc(UPT_REG_IRQ_STAT, 32'h5);
        rdc(UPT_REG_STATUS, st(sc, 1'b1, 1'b1, 1'b1));
        pins(20, 3'h7);
        wr(UPT_REG_IRQ_STAT, 32'h7);
        pins(2, 3'h3);
        $display("test mismatch done");
        exp_m[4] = 8'hFF;
        wr(UPT_REG_CTRL, 32'h1);
        // a write landing during readout is dropped
        nvm(0, 8'h00);
        exp_m[0] = 8'hC0;
        idle();
        rdc(UPT_REG_STATUS, st(sc, 1'b1, 1'b0, 1'b1));
        rdc(UPT_REG_MIRROR, 32'hC0);
        rdc(UPT_REG_MIRROR + 8'h10, 32'hFF);
        wr(8'h24, 32'hFFFF_FFFF);
        rdc(8'h24, 32'h0);
        $display("test recovery done");
        end_sim();
    end
    initial
    begin
        #50us;
        num_errors++;
        end_sim();
    end
endmodule // user_otp_error_detect_tb
`default_nettype wire
